// ===== eth_pio_pkg.sv
/*
 * Shared constants for the Ethernet FIFO programmed-I/O block: register
 * addresses, transmit outcome field positions, watermark steps and FSM states.
 * Assumes both ends, the checker and the testbench import it whole.
 */
// ============================================================
// Summary of operation
// R01 - Primary address write pushes word to transmit FIFO
// R02 - Host writes only while space flag set
// R03 - Middle words primary, final word last-word address
// R04 - Interrupts off: last-word write starts transmission
// R05 - Interrupts on: start at watermark byte count
// R06 - Data address read pops receive FIFO word
// R07 - Host reads receive data after ready cleared
// R08 - Host reads receive status before clearing ready
// R09 - DMA mode clears receive ready automatically
// R10 - Frame end loads outcome then sets done
// R11 - DMA mode copies outcome low half to descriptor
// R12 - Success bit reflects last frame sent cleanly
// R13 - Success drains frame, flags return, done raised
// R14 - Bit 14 marks broadcast destination
// R15 - Bit 13 marks multicast destination
// R16 - Bit 12 marks late collision abort
// R17 - Bit 11 marks excessive deferral abort
// R18 - Bit 10 marks excessive collision abort
// R19 - Abort flushes frame, raises done, restores flags
// R20 - Frame done cleared only by host write-one
// R21 - Receive ready cleared by host write-one
// R22 - Space flag high while FIFO accepts word
// R23 - Outcome read side-effect free, upper half zero
package eth_pio_pkg;
	// ============================================================
	// Register addresses
	localparam logic [31:0] FIFO_DATA_ADDR = 32'hff800008;
	localparam logic [31:0] FIFO_LAST_ADDR = 32'hff80000c;
	localparam logic [31:0] TX_OUTCOME_ADDR = 32'hff800010;
	localparam logic [31:0] RX_STATUS_ADDR = 32'hff800014;

	// ============================================================
	// Transmit outcome fields and reset
	localparam int TXST_OK = 15;
	localparam int TXST_BCAST = 14;
	localparam int TXST_MCAST = 13;
	localparam int TXST_LATE = 12;
	localparam int TXST_DEFER = 11;
	localparam int TXST_MANY = 10;
	localparam logic [15:0] TX_OUTCOME_RESET = 16'h0000;

	// ============================================================
	// Sizes and watermark
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0] WM_STEP_BYTES = 8'h10;

	// Watermark select to byte threshold: 16, 32, 48, 64
	function automatic logic [7:0] wm_bytes(input logic [1:0] sel);
		wm_bytes = 8'({6'h00, sel} + 8'h01) * WM_STEP_BYTES;
	endfunction : wm_bytes

	// ============================================================
	// State machines
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_SEND = 3'b010,
		TX_FLUSH = 3'b100
	} tx_state_e;

	typedef enum logic [5:0] {
		H_IDLE = 6'b000001,
		H_WAIT_TXST = 6'b000010,
		H_WAIT_RXST = 6'b000100,
		H_WAIT_RX = 6'b001000,
		H_GAP = 6'b010000,
		H_SPARE = 6'b100000
	} host_state_e;
endpackage : eth_pio_pkg

// ===== eth_pio_if.sv
/*
 * Carrier between host and device ends: register access strobes plus the
 * general status flags and their write-one-to-clear strobes.
 * Assumes both ends share one clock; reads answer one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
interface eth_pio_if;
	logic [31:0] addr;
	logic wr;
	logic rd;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic rvalid;
	logic tx_space_avail;
	logic tx_fifo_half_free;
	logic tx_frame_done;
	logic rx_packet_ready;
	logic [15:0] rx_avail_bytes;
	logic tx_done_clr;
	logic rx_ready_clr;

	modport device (input addr, wr, rd, wdata, tx_done_clr, rx_ready_clr,
		output rdata, rvalid, tx_space_avail, tx_fifo_half_free, tx_frame_done, rx_packet_ready, rx_avail_bytes);
	modport host (output addr, wr, rd, wdata, tx_done_clr, rx_ready_clr,
		input rdata, rvalid, tx_space_avail, tx_fifo_half_free, tx_frame_done, rx_packet_ready, rx_avail_bytes);
endinterface : eth_pio_if
`default_nettype wire

// ===== eth_pio_device.sv
/*
 * Device end: transmit and receive FIFOs, transmit start control, outcome
 * capture and receive-ready handling, plus the generic FIFO they use.
 * Assumes the MAC engine reports one outcome per started frame.
 */
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Generic FIFO
module eth_pio_fifo #(
	parameter int W = 33,
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH)
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready,
	// Fill level
	output logic [AW:0] count
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_s;
	fifo_s q, d;
	logic push, pop;

	// Handshakes on both sides
	assign in_ready = q.cnt != (AW+1)'(DEPTH);
	assign out_valid = q.cnt != '0;
	assign out_data = q.mem[q.rp];
	assign count = q.cnt;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and level update
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp = AW'(q.wp + 1'b1);
		end
		if (pop) begin
			d.rp = AW'(q.rp + 1'b1);
		end
		d.cnt = (AW+1)'(q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
	end

	// Storage needs no reset, pointers do
	always_ff @(posedge clock) begin
		q <= d;
		if (reset) begin
			q.wp <= '0;
			q.rp <= '0;
			q.cnt <= '0;
		end
	end
endmodule : eth_pio_fifo

// ============================================================
// Device end
module eth_pio_device import eth_pio_pkg::*; #(
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Host link
	eth_pio_if.device bus,
	// Control settings
	input wire logic tx_done_int_en,
	input wire logic [1:0] tx_watermark_sel,
	input wire logic dma_mode,
	// MAC transmit stream
	output logic mac_tx_valid,
	output logic [31:0] mac_tx_data,
	output logic mac_tx_last,
	input wire logic mac_tx_ready,
	// MAC transmit outcome report
	input wire logic mac_tx_report,
	input wire logic mac_tx_ok,
	input wire logic mac_tx_bcast,
	input wire logic mac_tx_mcast,
	input wire logic mac_tx_late_coll,
	input wire logic mac_tx_long_defer,
	input wire logic mac_tx_many_coll,
	// MAC receive stream
	input wire logic mac_rx_valid,
	input wire logic [31:0] mac_rx_data,
	output logic mac_rx_ready,
	input wire logic mac_rx_end,
	input wire logic [31:0] mac_rx_status,
	// DMA descriptor side
	output logic [15:0] desc_status_field,
	output logic desc_status_write,
	output logic rx_status_auto_read
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		tx_state_e tx_st;
		logic last_popped;
		logic start_req;
		logic [15:0] outcome;
		logic tx_done;
		logic rx_ready;
		logic [31:0] rx_status;
		logic [31:0] rdata;
		logic rvalid;
		logic [15:0] desc;
		logic desc_wr;
		logic rx_auto;
	} dev_s;
	dev_s q, d;

	logic txf_in_valid, txf_in_ready, txf_out_valid, txf_out_ready;
	logic [32:0] txf_in_data, txf_out_data;
	logic [AW:0] txf_count, rxf_count;
	logic rxf_out_valid, rxf_out_ready;
	logic [31:0] rxf_out_data;
	logic wr_data, wr_last, rd_data;
	logic [15:0] tx_bytes;

	// Address decode of host strobes
	assign wr_data = bus.wr && bus.addr == FIFO_DATA_ADDR;
	assign wr_last = bus.wr && bus.addr == FIFO_LAST_ADDR;
	assign rd_data = bus.rd && bus.addr == FIFO_DATA_ADDR;
	assign tx_bytes = 16'({txf_count, 2'b00});

	// Transmit FIFO fill: word plus end-of-frame mark
	assign txf_in_valid = wr_data || wr_last; // R01
	assign txf_in_data = {wr_last, bus.wdata};

	// Drain only while sending and before the frame end, or while flushing
	assign txf_out_ready = (q.tx_st == TX_SEND && !q.last_popped && mac_tx_ready) || q.tx_st == TX_FLUSH;
	assign mac_tx_valid = q.tx_st == TX_SEND && !q.last_popped && txf_out_valid;
	assign mac_tx_data = txf_out_data[31:0];
	assign mac_tx_last = txf_out_data[32];

	// Receive FIFO pops only once the packet is released to the host
	assign rxf_out_ready = rd_data && !q.rx_ready; // R06

	// Status flags; done holds the space and half-free flags off, as does a flush in progress
	assign bus.tx_space_avail = txf_in_ready && !q.tx_done && q.tx_st != TX_FLUSH; // R22 R13 R19
	assign bus.tx_fifo_half_free = txf_count <= (AW+1)'(DEPTH/2) && !q.tx_done && q.tx_st != TX_FLUSH;
	assign bus.tx_frame_done = q.tx_done;
	assign bus.rx_packet_ready = q.rx_ready;
	assign bus.rx_avail_bytes = q.rx_ready ? 16'h0000 : 16'({rxf_count, 2'b00});
	assign bus.rdata = q.rdata;
	assign bus.rvalid = q.rvalid;
	assign desc_status_field = q.desc;
	assign desc_status_write = q.desc_wr;
	assign rx_status_auto_read = q.rx_auto;

	eth_pio_fifo #(.W(33), .DEPTH(DEPTH)) tx_fifo (
		.clock(clock),
		.reset(reset),
		.in_valid(txf_in_valid),
		.in_data(txf_in_data),
		.in_ready(txf_in_ready),
		.out_valid(txf_out_valid),
		.out_data(txf_out_data),
		.out_ready(txf_out_ready),
		.count(txf_count)
	);

	eth_pio_fifo #(.W(32), .DEPTH(DEPTH)) rx_fifo (
		.clock(clock),
		.reset(reset),
		.in_valid(mac_rx_valid),
		.in_data(mac_rx_data),
		.in_ready(mac_rx_ready),
		.out_valid(rxf_out_valid),
		.out_data(rxf_out_data),
		.out_ready(rxf_out_ready),
		.count(rxf_count)
	);

	// ============================================================
	// Next-state logic
	always_comb begin
		d = q;
		d.rvalid = bus.rd;
		d.desc_wr = 1'b0;
		d.rx_auto = 1'b0;

		// Register reads; outcome read has no side effect
		case (bus.addr)
			FIFO_DATA_ADDR: d.rdata = rxf_out_valid && !q.rx_ready ? rxf_out_data : 32'h00000000;
			TX_OUTCOME_ADDR: d.rdata = {16'h0000, q.outcome}; // R23
			RX_STATUS_ADDR: d.rdata = q.rx_status;
			default: d.rdata = 32'h00000000;
		endcase

		// Start request from a last-word write with interrupts off
		if (wr_last && !tx_done_int_en) begin
			d.start_req = 1'b1; // R04
		end

		case (q.tx_st)
			TX_IDLE: begin
				d.last_popped = 1'b0;
				if (tx_done_int_en ? (tx_bytes >= {8'h00, wm_bytes(tx_watermark_sel)}) : q.start_req) begin
					d.tx_st = TX_SEND; // R05
					d.start_req = 1'b0;
				end
			end
			TX_SEND: begin
				if (txf_out_valid && txf_out_ready && txf_out_data[32]) begin
					d.last_popped = 1'b1;
				end
				if (mac_tx_report) begin
					d.outcome = TX_OUTCOME_RESET;
					d.outcome[TXST_OK] = mac_tx_ok; // R12
					d.outcome[TXST_BCAST] = mac_tx_bcast; // R14
					d.outcome[TXST_MCAST] = mac_tx_mcast; // R15
					d.outcome[TXST_LATE] = mac_tx_late_coll; // R16
					d.outcome[TXST_DEFER] = mac_tx_long_defer; // R17
					d.outcome[TXST_MANY] = mac_tx_many_coll; // R18
					d.tx_done = 1'b1; // R10
					if (dma_mode) begin
						d.desc = d.outcome; // R11
						d.desc_wr = 1'b1;
					end
					// Abort before the end mark left: drop the rest of the frame
					d.tx_st = (q.last_popped || (txf_out_valid && txf_out_ready && txf_out_data[32])) ? TX_IDLE : TX_FLUSH; // R13 R19
				end
			end
			TX_FLUSH: begin
				if (txf_out_valid && txf_out_data[32]) begin
					d.tx_st = TX_IDLE; // R19
				end
			end
			default: d.tx_st = TX_IDLE;
		endcase

		// Done clears on a host write-one; a new completion wins
		if (bus.tx_done_clr && !(q.tx_st == TX_SEND && mac_tx_report)) begin
			d.tx_done = 1'b0; // R20
		end

		// Receive ready: host clear, or automatic clear in DMA mode
		if (q.rx_ready && dma_mode) begin
			d.rx_auto = 1'b1; // R09
			d.rx_ready = 1'b0;
		end
		if (bus.rx_ready_clr) begin
			d.rx_ready = 1'b0; // R21
		end
		if (mac_rx_end) begin
			d.rx_ready = 1'b1;
			d.rx_status = mac_rx_status;
		end
	end

	// ============================================================
	// State register
	always_ff @(posedge clock) begin
		if (reset) begin
			q <= '{tx_st: TX_IDLE, outcome: TX_OUTCOME_RESET, default: '0};
		end else begin
			q <= d;
		end
	end
endmodule : eth_pio_device
`default_nettype wire

// ===== eth_pio_host.sv
/*
 * Host end: feeds transmit words through the FIFO data addresses, services
 * frame-done and, outside DMA mode, receive-ready, and reads received words out.
 * Assumes the device answers each read exactly one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module eth_pio_host import eth_pio_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Device link
	eth_pio_if.host bus,
	// Mode
	input wire logic dma_mode,
	// User transmit words
	input wire logic tx_valid,
	input wire logic [31:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready,
	// User receive words
	output logic rx_valid,
	output logic [31:0] rx_data,
	// Frame outcomes
	output logic outcome_valid,
	output logic [15:0] outcome,
	output logic rx_status_valid,
	output logic [31:0] rx_status
);
	typedef struct packed {
		host_state_e st;
		logic [31:0] addr;
		logic wr;
		logic rd;
		logic [31:0] wdata;
		logic tx_clr;
		logic rx_clr;
		logic tx_ready;
		logic rx_valid;
		logic [31:0] rx_data;
		logic outcome_valid;
		logic [15:0] outcome;
		logic rxst_valid;
		logic [31:0] rxst;
		logic rx_open;
	} host_s;
	host_s q, d;

	assign bus.addr = q.addr;
	assign bus.wr = q.wr;
	assign bus.rd = q.rd;
	assign bus.wdata = q.wdata;
	assign bus.tx_done_clr = q.tx_clr;
	assign bus.rx_ready_clr = q.rx_clr;
	assign tx_ready = q.tx_ready;
	assign rx_valid = q.rx_valid;
	assign rx_data = q.rx_data;
	assign outcome_valid = q.outcome_valid;
	assign outcome = q.outcome;
	assign rx_status_valid = q.rxst_valid;
	assign rx_status = q.rxst;

	// ============================================================
	// One access at a time; a gap cycle lets the flags settle
	always_comb begin
		d = q;
		d.wr = 1'b0;
		d.rd = 1'b0;
		d.tx_clr = 1'b0;
		d.rx_clr = 1'b0;
		d.tx_ready = 1'b0;
		d.rx_valid = 1'b0;
		d.outcome_valid = 1'b0;
		d.rxst_valid = 1'b0;

		// Data reads open only once a packet was announced, so partial packets stay put
		if (!bus.rx_packet_ready && bus.rx_avail_bytes == 16'h0000) begin
			d.rx_open = 1'b0;
		end
		if (bus.rx_packet_ready) begin
			d.rx_open = 1'b1; // R07
		end
		case (q.st)
			H_IDLE: begin
				if (bus.tx_frame_done) begin
					d.rd = 1'b1;
					d.addr = TX_OUTCOME_ADDR;
					d.st = H_WAIT_TXST;
				end else if (bus.rx_packet_ready && !dma_mode) begin
					d.rd = 1'b1; // R08
					d.addr = RX_STATUS_ADDR;
					d.st = H_WAIT_RXST;
				end else if (q.rx_open && !bus.rx_packet_ready && bus.rx_avail_bytes != 16'h0000) begin
					d.rd = 1'b1; // R07
					d.addr = FIFO_DATA_ADDR;
					d.st = H_WAIT_RX;
				end else if (tx_valid && bus.tx_space_avail) begin
					d.wr = 1'b1; // R02
					d.addr = tx_last ? FIFO_LAST_ADDR : FIFO_DATA_ADDR; // R03
					d.wdata = tx_data;
					d.tx_ready = 1'b1;
					d.st = H_GAP;
				end
			end
			H_WAIT_TXST: begin
				if (bus.rvalid) begin
					d.outcome = bus.rdata[15:0];
					d.outcome_valid = 1'b1;
					d.tx_clr = 1'b1; // R20
					d.st = H_GAP;
				end
			end
			H_WAIT_RXST: begin
				if (bus.rvalid) begin
					d.rxst = bus.rdata;
					d.rxst_valid = 1'b1;
					d.rx_clr = 1'b1; // R21 R08
					d.st = H_GAP;
				end
			end
			H_WAIT_RX: begin
				if (bus.rvalid) begin
					d.rx_data = bus.rdata;
					d.rx_valid = 1'b1;
					d.st = H_GAP;
				end
			end
			H_GAP: d.st = H_IDLE;
			default: d.st = H_IDLE;
		endcase
	end

	// ============================================================
	// State register
	always_ff @(posedge clock) begin
		if (reset) begin
			q <= '{st: H_IDLE, default: '0};
		end else begin
			q <= d;
		end
	end
endmodule : eth_pio_host
`default_nettype wire

// ===== eth_pio_link_asserts.sv
/*
 * Link checker: timing relations on the host-device carrier signals.
 * Assumes one clock and a synchronous active-high reset shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
module eth_pio_link_asserts import eth_pio_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Register strobes
	input wire logic [31:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	// Status flags
	input wire logic tx_space_avail,
	input wire logic tx_fifo_half_free,
	input wire logic tx_frame_done,
	input wire logic rx_packet_ready,
	input wire logic [15:0] rx_avail_bytes,
	input wire logic tx_done_clr
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	// ====================
	// Read steps
	sequence s_read(logic [31:0] a);
		rd && addr == a;
	endsequence
	sequence s_answer;
		rvalid;
	endsequence
	property p_rd_answer;
		rd |=> s_answer;
	endproperty
	property p_rvalid_cause;
		rvalid |-> $past(rd);
	endproperty
	property p_outcome_upper;
		s_read(TX_OUTCOME_ADDR) |=> s_answer ##0 rdata[31:16] == 16'h0000;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
	a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without read");
	a_outcome_upper: assert property (p_outcome_upper) else $error("outcome upper half not zero");
	// ====================
	// Flags; done blocks space so a stale frame cannot be overwritten
	property p_done_blocks;
		tx_frame_done |-> !tx_space_avail && !tx_fifo_half_free;
	endproperty
	property p_half_in_space;
		tx_fifo_half_free |-> tx_space_avail;
	endproperty
	property p_done_sticky;
		tx_frame_done && !tx_done_clr |=> tx_frame_done;
	endproperty
	property p_clr_when_set;
		tx_done_clr |-> tx_frame_done;
	endproperty
	property p_rx_hidden;
		rx_packet_ready |-> rx_avail_bytes == 16'h0000;
	endproperty
	property p_write_space;
		wr && (addr == FIFO_DATA_ADDR || addr == FIFO_LAST_ADDR) |-> tx_space_avail;
	endproperty
	a_done_blocks: assert property (p_done_blocks) else $error("space shown while done");
	a_half_in_space: assert property (p_half_in_space) else $error("half free without space");
	a_done_sticky: assert property (p_done_sticky) else $error("done dropped without clear");
	a_clr_when_set: assert property (p_clr_when_set) else $error("clear while done low");
	a_rx_hidden: assert property (p_rx_hidden) else $error("bytes shown while ready");
	a_write_space: assert property (p_write_space) else $error("write without space");
endmodule : eth_pio_link_asserts
`default_nettype wire

// ===== tb_eth_fifo_pio_tx_status.sv
/*
 * Testbench: host and device ends joined by the carrier, MAC side driven here.
 * Assumes the host services done, and receive-ready outside DMA mode, by itself.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_eth_fifo_pio_tx_status import eth_pio_pkg::*;;
	// ====================
	// Stimulus and notes
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic tx_done_int_en = 1'b0;
	logic [1:0] tx_watermark_sel = 2'h0;
	logic dma_mode = 1'b0;
	logic mac_tx_valid, mac_tx_last, desc_status_write, rx_status_auto_read, mac_rx_ready;
	logic mac_tx_ready = 1'b0;
	logic mac_tx_report = 1'b0;
	logic [5:0] flags = 6'h00;
	logic [31:0] mac_tx_data, rx_data, rx_status;
	logic mac_rx_valid = 1'b0;
	logic mac_rx_end = 1'b0;
	logic [31:0] mac_rx_data = 32'h00000000;
	logic [31:0] mac_rx_status = 32'h00000000;
	logic [15:0] desc_status_field, outcome;
	logic tx_valid = 1'b0;
	logic tx_last = 1'b0;
	logic [31:0] tx_data = 32'h00000000;
	logic tx_ready, rx_valid, outcome_valid, rx_status_valid;
	logic mac_go = 1'b0;
	int fails = 0;
	int check_count = 0;
	int tx_popped = 0;
	int rx_seen = 0;
	int auto_seen = 0;
	logic [32:0] exp_tx[$], exp_out[$], exp_desc[$], exp_rs[$], exp_rx[$];
	logic [5:0] codes [6] = '{6'b100000, 6'b110000, 6'b101000, 6'b000100, 6'b000010, 6'b000001};

	always #2.5 clock = ~clock;

	// ====================
	// Both ends and the checker
	eth_pio_if i_eth_pio_if ();
	eth_pio_device i_eth_pio_device (.clock(clock), .reset(reset), .bus(i_eth_pio_if.device),
		.tx_done_int_en(tx_done_int_en), .tx_watermark_sel(tx_watermark_sel), .dma_mode(dma_mode),
		.mac_tx_valid(mac_tx_valid), .mac_tx_data(mac_tx_data), .mac_tx_last(mac_tx_last),
		.mac_tx_ready(mac_tx_ready), .mac_tx_report(mac_tx_report), .mac_tx_ok(flags[5]),
		.mac_tx_bcast(flags[4]), .mac_tx_mcast(flags[3]), .mac_tx_late_coll(flags[2]),
		.mac_tx_long_defer(flags[1]), .mac_tx_many_coll(flags[0]), .mac_rx_valid(mac_rx_valid),
		.mac_rx_data(mac_rx_data), .mac_rx_ready(mac_rx_ready), .mac_rx_end(mac_rx_end),
		.mac_rx_status(mac_rx_status), .desc_status_field(desc_status_field),
		.desc_status_write(desc_status_write), .rx_status_auto_read(rx_status_auto_read));
	eth_pio_host i_eth_pio_host (.clock(clock), .reset(reset), .bus(i_eth_pio_if.host), .dma_mode(dma_mode),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .outcome_valid(outcome_valid), .outcome(outcome),
		.rx_status_valid(rx_status_valid), .rx_status(rx_status));
	eth_pio_link_asserts i_eth_pio_link_asserts (.clock(clock), .reset(reset), .addr(i_eth_pio_if.addr),
		.wr(i_eth_pio_if.wr), .rd(i_eth_pio_if.rd), .rdata(i_eth_pio_if.rdata), .rvalid(i_eth_pio_if.rvalid),
		.tx_space_avail(i_eth_pio_if.tx_space_avail), .tx_fifo_half_free(i_eth_pio_if.tx_fifo_half_free),
		.tx_frame_done(i_eth_pio_if.tx_frame_done), .rx_packet_ready(i_eth_pio_if.rx_packet_ready),
		.rx_avail_bytes(i_eth_pio_if.rx_avail_bytes), .tx_done_clr(i_eth_pio_if.tx_done_clr));

	// ====================
	// Checking and waiting
	task give_verdict;
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	task check(input string n, input logic [32:0] seen, input logic [32:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", n, exp, seen);
		end
	endtask : check
	task automatic cmp(input string n, input logic [32:0] seen, ref logic [32:0] q[$]);
		if (q.size() == 0) check(n, seen, (seen === 33'h0) ? 33'h1 : 33'h0);
		else check(n, seen, q.pop_front());
	endtask : cmp
	// Every wait is bounded so a stuck handshake still reaches the verdict
	task automatic tick(ref int k);
		@(posedge clock);
		k++;
		if (k > 3000) begin
			fails++;
			$display("unexpected wait: expected event, seen timeout");
			give_verdict();
		end
	endtask : tick

	// ====================
	// Transmit frames, thr is the watermark in words or 0 for last-word start
	task automatic put_word(input logic [31:0] w, input logic l);
		int k;
		@(posedge clock);
		tx_valid <= 1'b1;
		tx_data <= w;
		tx_last <= l;
		k = 0;
		do tick(k); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
		tx_data <= ~w;
	endtask : put_word
	task automatic frame(input int n, input logic [5:0] c, input int thr);
		logic [31:0] w;
		logic [15:0] e;
		int k;
		tx_popped = 0;
		mac_go <= (thr != 0);
		for (int i = 1; i <= n; i++) begin
			w = $urandom();
			if (c[5]) exp_tx.push_back({i == n, w});
			put_word(w, i == n);
			if ((thr == 0 && i == n - 1) || i == thr - 1) begin
				repeat (4) @(posedge clock);
				check("early start", {32'h0, mac_tx_valid}, 33'h0);
			end
		end
		if (thr == 0) begin
			repeat (2) @(posedge clock);
			check("space", {32'h0, i_eth_pio_if.tx_space_avail}, {32'h0, n < FIFO_DEPTH});
		end
		mac_go <= c[5];
		k = 0;
		if (c[5]) while (tx_popped != n) tick(k);
		else while (mac_tx_valid !== 1'b1) tick(k);
		e = 16'(c) << TXST_MANY;
		if (dma_mode) exp_desc.push_back({17'h0, e});
		else exp_out.push_back({17'h0, e});
		@(posedge clock);
		mac_go <= 1'b0;
		mac_tx_report <= 1'b1;
		flags <= c;
		@(posedge clock);
		mac_tx_report <= 1'b0;
		flags <= ~c;
		while (i_eth_pio_if.tx_frame_done !== 1'b0 || exp_out.size() + exp_desc.size() != 0) tick(k);
		// A flush after an abort may still be running; flags return once it ends
		while (i_eth_pio_if.tx_space_avail !== 1'b1) tick(k);
		check("flags back", {31'h0, i_eth_pio_if.tx_space_avail, i_eth_pio_if.tx_fifo_half_free}, 33'h3);
	endtask : frame

	// ====================
	// Receive packets
	task automatic rx_packet(input int n);
		logic [31:0] w;
		int k;
		int target;
		target = rx_seen + n;
		auto_seen = 0;
		for (int i = 0; i < n; i++) begin
			w = $urandom();
			exp_rx.push_back({1'b0, w});
			@(posedge clock);
			mac_rx_valid <= 1'b1;
			mac_rx_data <= w;
			k = 0;
			do tick(k); while (mac_rx_ready !== 1'b1);
			mac_rx_valid <= 1'b0;
			mac_rx_data <= ~w;
		end
		w = $urandom();
		if (!dma_mode) exp_rs.push_back({1'b0, w});
		@(posedge clock);
		mac_rx_end <= 1'b1;
		mac_rx_status <= w;
		@(posedge clock);
		mac_rx_end <= 1'b0;
		mac_rx_status <= ~w;
		check("rx room", {32'h0, mac_rx_ready}, {32'h0, n < FIFO_DEPTH});
		k = 0;
		while (rx_seen != target || exp_rs.size() != 0) tick(k);
		check("auto read", 33'(auto_seen), {32'h0, dma_mode});
	endtask : rx_packet

	// MAC drain stalls at random while allowed
	always @(posedge clock) mac_tx_ready <= mac_go && ($urandom() % 2 == 0);

	// Outputs are taken at the falling edge, where they are settled
	always @(negedge clock) begin
		if (!reset) begin
			if (mac_tx_valid && mac_tx_ready) begin
				cmp("mac word", {mac_tx_last, mac_tx_data}, exp_tx);
				tx_popped++;
			end
			if (outcome_valid && !dma_mode) cmp("outcome", {17'h0, outcome}, exp_out);
			if (desc_status_write) cmp("descriptor", {17'h0, desc_status_field}, exp_desc);
			if (rx_status_valid && !dma_mode) cmp("rx status", {1'b0, rx_status}, exp_rs);
			if (rx_valid) begin
				cmp("rx word", {1'b0, rx_data}, exp_rx);
				rx_seen++;
			end
			if (rx_status_auto_read) auto_seen++;
		end
	end

	// ====================
	// Main sequence
	initial begin
		void'($urandom(88));
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		for (int i = 0; i < 6; i++) frame(i == 0 ? 16 : 3 + i, codes[i], 0);
		tx_done_int_en <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			tx_watermark_sel <= 2'(s);
			frame(4 * s + 5, 6'b100000, 4 * s + 4);
		end
		tx_done_int_en <= 1'b0;
		rx_packet(1);
		rx_packet(16);
		dma_mode <= 1'b1;
		frame(5, 6'b110000, 0);
		frame(4, 6'b000100, 0);
		rx_packet(5);
		give_verdict();
	end
endmodule : tb_eth_fifo_pio_tx_status
`default_nettype wire
